/* File: core/srpp_pkg.sv */
// Package: register map, field positions, constants and carrier type of the serial receiver.
package srpp_pkg;

   localparam int unsigned APB_ADDR_W = 12;
   localparam int unsigned IDX_W = 10;

   // Register indices; the APB byte address is four times the index.
   localparam logic [IDX_W-1:0] IDX_RX_PACKET_CONTROL = 10'h101;
   localparam logic [IDX_W-1:0] IDX_RX_MAX_SIZE_LOW = 10'h102;
   localparam logic [IDX_W-1:0] IDX_RX_MAX_SIZE_HIGH = 10'h103;
   localparam logic [IDX_W-1:0] IDX_RX_PACKET_STATUS = 10'h104;
   localparam logic [IDX_W-1:0] IDX_RX_PACKET_STATUS_LATCHED = 10'h105;
   localparam logic [IDX_W-1:0] IDX_RX_IRQ_ENABLE = 10'h106;
   localparam logic [IDX_W-1:0] IDX_RX_MODE_CONFIG = 10'h120;

   // Fields of rx_packet_control.
   localparam int unsigned CTL_FCS_PROCESSING_DISABLE = 5;
   localparam int unsigned CTL_FCS16_SELECT = 4;
   localparam int unsigned CTL_FCS_PASS_THROUGH = 3;
   localparam int unsigned CTL_DESCRAMBLE_DISABLE = 2;
   localparam int unsigned CTL_BIT_REORDER_ENABLE = 1;
   localparam int unsigned CTL_CLEAR_CHANNEL_ENABLE = 0;
   localparam logic [7:0] CTL_WRITE_MASK = 8'h3f;

   // Field of rx_mode_config.
   localparam int unsigned MODE_X86_ENABLE = 0;

   // Fields of rx_packet_status and the low three bits of rx_packet_status_latched.
   localparam int unsigned ST_FCS_ERR_COUNT_NONZERO = 2;
   localparam int unsigned ST_ABORT_COUNT_NONZERO = 1;
   localparam int unsigned ST_SIZE_VIOL_COUNT_NONZERO = 0;

   // Fields of rx_packet_status_latched.
   localparam int unsigned LAT_FCS_ERR_PKT = 7;
   localparam int unsigned LAT_ABORT_PKT = 6;
   localparam int unsigned LAT_INVALID_PKT = 5;
   localparam int unsigned LAT_SMALL_PKT = 4;
   localparam int unsigned LAT_LARGE_PKT = 3;

   // Reset values.
   localparam logic [7:0] RST_RX_PACKET_CONTROL = 8'h00;
   localparam logic [7:0] RST_RX_MAX_SIZE_LOW = 8'he0;
   localparam logic [7:0] RST_RX_MAX_SIZE_HIGH = 8'h07;
   localparam logic [7:0] RST_RX_PACKET_STATUS_LATCHED = 8'h00;
   localparam logic [7:0] RST_RX_IRQ_ENABLE = 8'h00;
   localparam logic [7:0] RST_RX_MODE_CONFIG = 8'h00;

   // Framing constants.
   localparam logic [15:0] MAX_PKT_LIMIT = 16'h07e0;
   localparam logic [7:0] FLAG_BYTE = 8'h7e;
   localparam logic [7:0] ESC_BYTE = 8'h7d;
   localparam logic [7:0] ESC_XOR = 8'h20;
   localparam int unsigned SCR_LEN = 43;
   localparam logic [2:0] FCS16_BYTES = 3'h2;
   localparam logic [2:0] FCS32_BYTES = 3'h4;
   localparam logic [31:0] CRC32_POLY = 32'hedb88320;
   localparam logic [31:0] CRC16_POLY = 32'h00008408;
   localparam logic [31:0] CRC32_INIT = 32'hffffffff;
   localparam logic [31:0] CRC16_INIT = 32'h0000ffff;
   localparam logic [31:0] CRC32_GOOD = 32'hdebb20e3;
   localparam logic [31:0] CRC16_GOOD = 32'h0000f0b8;

   typedef struct packed {
      logic [7:0] data;
      logic valid;
      logic eop;
      logic err;
   } srpp_out_t;

endpackage

/* File: core/srpp_top.sv */
// Serial receive packet processor: link sampling, descrambler, deframer, FCS, sizing, APB registers.
`timescale 1ns/1ps
module srpp_top #(
   parameter int unsigned CNT_W = 24
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [srpp_pkg::APB_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_clk_pin,
   input wire logic rx_data_pin,
   input wire logic rx_sync_pin,
   input wire logic [15:0] min_pkt_size,
   output srpp_pkg::srpp_out_t rx_out,
   output logic irq
);
   import srpp_pkg::*;

   if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
      $error("CNT_W must lie between 1 and 32.");
   end

   function automatic logic reg_known(input logic [IDX_W-1:0] idx);
      return idx == IDX_RX_PACKET_CONTROL || idx == IDX_RX_MAX_SIZE_LOW ||
             idx == IDX_RX_MAX_SIZE_HIGH || idx == IDX_RX_PACKET_STATUS ||
             idx == IDX_RX_PACKET_STATUS_LATCHED || idx == IDX_RX_IRQ_ENABLE ||
             idx == IDX_RX_MODE_CONFIG;
   endfunction

   function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] b,
                                            input logic is32);
      logic [31:0] c;
      c = crc;
      for (int i = 0; i < 8; i++) begin
         if (c[0] ^ b[i]) begin
            c = (c >> 1) ^ (is32 ? CRC32_POLY : CRC16_POLY);
         end else begin
            c = c >> 1;
         end
      end
      return c;
   endfunction

   // ---------------- Registers ----------------
   logic [7:0] ctrl_q;
   logic [7:0] max_lo_q;
   logic [7:0] max_hi_q;
   logic [7:0] ie_q;
   logic [7:0] mode_q;
   logic [7:0] lat_q;
   logic [2:0] stat_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;

   wire [IDX_W-1:0] idx = paddr[APB_ADDR_W-1:2];
   wire wr_ok = psel & penable & pready_q & pwrite & reg_known(idx);

   // Link pins are asynchronous to clk, so each passes two flip-flops first.
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic link_clk_prev_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         link_clk_prev_q <= 1'b0;
      end else begin
         sync1_q <= {rx_clk_pin, rx_data_pin, rx_sync_pin};
         sync2_q <= sync1_q;
         link_clk_prev_q <= sync2_q[2];
      end
   end

   wire bit_ev = sync2_q[2] & ~link_clk_prev_q;
   wire raw_bit = sync2_q[1];
   wire sync_bit = sync2_q[0];

   // ---------------- Mode decoding ----------------
   wire x86 = mode_q[MODE_X86_ENABLE];
   wire clear_mode = ctrl_q[CTL_CLEAR_CHANNEL_ENABLE];
   wire hdlc_mode = ~x86 & ~clear_mode;
   wire fcs_on = ~ctrl_q[CTL_FCS_PROCESSING_DISABLE] | x86;
   wire fcs32 = x86 | ~ctrl_q[CTL_FCS16_SELECT];
   wire [2:0] fcs_n = fcs_on ? (fcs32 ? FCS32_BYTES : FCS16_BYTES) : 3'h0;
   wire drop_fcs = fcs_on & (x86 | ~ctrl_q[CTL_FCS_PASS_THROUGH]);
   wire [2:0] drop_n = (drop_fcs & ~clear_mode) ? fcs_n : 3'h0;
   wire [15:0] max_prog = {max_hi_q, max_lo_q};
   wire [15:0] max_cap = clear_mode ? MAX_PKT_LIMIT : MAX_PKT_LIMIT + {13'h0, fcs_n};
   wire [15:0] max_eff = (max_prog > max_cap) ? max_cap : max_prog;
   wire discard_all = max_eff < min_pkt_size;

   // ---------------- Descrambler ----------------
   logic [SCR_LEN-1:0] scr_q;
   wire dbit = ctrl_q[CTL_DESCRAMBLE_DISABLE] ? raw_bit : raw_bit ^ scr_q[SCR_LEN-1];

   always_ff @(posedge clk) begin
      if (rst) begin
         scr_q <= '0;
      end else if (bit_ev) begin
         scr_q <= {scr_q[SCR_LEN-2:0], raw_bit};
      end
   end

   // ---------------- HDLC flag, abort and destuffing ----------------
   // Bits run through an 8-bit window so that flag bits never reach the byte assembler.
   logic [7:0] win_q;
   logic [7:0] vld_q;
   logic [2:0] ones_q;
   wire [7:0] win_nx = {win_q[6:0], dbit};
   wire flag_hit = hdlc_mode & bit_ev & (win_nx == FLAG_BYTE);
   wire abort_hit = hdlc_mode & bit_ev & dbit & (ones_q == 3'h6);
   wire stuffed = ~dbit & (ones_q == 3'h5);

   always_ff @(posedge clk) begin
      if (rst) begin
         win_q <= 8'h00;
         vld_q <= 8'h00;
         ones_q <= 3'h0;
      end else if (bit_ev) begin
         win_q <= win_nx;
         ones_q <= dbit ? ((ones_q == 3'h7) ? 3'h7 : ones_q + 3'h1) : 3'h0;
         if (flag_hit || abort_hit || !hdlc_mode) begin
            vld_q <= 8'h00;
         end else begin
            vld_q <= {vld_q[6:0], ~stuffed};
         end
      end
   end

   // ---------------- Byte assembly ----------------
   logic [7:0] sh_q;
   logic [2:0] bcnt_q;
   wire asm_bit = hdlc_mode ? win_q[7] : dbit;
   wire asm_v = bit_ev & (hdlc_mode ? vld_q[7] : 1'b1);
   wire [2:0] bcnt_base = (~hdlc_mode & sync_bit) ? 3'h0 : bcnt_q;
   wire [7:0] sh_nx = ctrl_q[CTL_BIT_REORDER_ENABLE] ? {asm_bit, sh_q[7:1]} :
                                                       {sh_q[6:0], asm_bit};
   wire byte_done = asm_v & (bcnt_base == 3'h7);
   wire [2:0] bcnt_nx = asm_v ? bcnt_base + 3'h1 : bcnt_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         sh_q <= 8'h00;
         bcnt_q <= 3'h0;
      end else begin
         if (asm_v) begin
            sh_q <= sh_nx;
         end
         if (flag_hit || abort_hit) begin
            bcnt_q <= 3'h0;
         end else begin
            bcnt_q <= bcnt_nx;
         end
      end
   end

   // ---------------- Byte-level framing ----------------
   logic in_pkt_q;
   logic esc_q;
   logic [15:0] cnt_q;
   logic [31:0] crc_q;
   logic big_q;
   logic data_ev;
   logic end_ev;
   logic abort_ev;
   logic [7:0] data_b;

   always_comb begin
      data_ev = 1'b0;
      end_ev = 1'b0;
      abort_ev = 1'b0;
      data_b = sh_nx;
      if (clear_mode) begin
         data_ev = byte_done;
      end else if (x86) begin
         if (byte_done) begin
            if (sh_nx == FLAG_BYTE) begin
               abort_ev = esc_q & in_pkt_q;
               end_ev = ~esc_q;
            end else if (sh_nx != ESC_BYTE) begin
               data_ev = in_pkt_q;
               data_b = esc_q ? sh_nx ^ ESC_XOR : sh_nx;
            end
         end
      end else begin
         data_ev = byte_done & in_pkt_q;
         end_ev = flag_hit;
         abort_ev = abort_hit & in_pkt_q & (cnt_q != 16'h0);
      end
   end

   wire [15:0] cnt_nx = data_ev ? cnt_q + 16'h1 : cnt_q;
   wire [31:0] crc_nx = data_ev ? crc_byte(crc_q, data_b, fcs32) : crc_q;
   wire big_nx = big_q | (data_ev & (cnt_nx > max_eff));
   wire chunk_end = clear_mode & data_ev & (cnt_nx >= max_eff);
   wire close_ev = ~clear_mode & end_ev & in_pkt_q & (cnt_nx != 16'h0);
   wire [31:0] crc_init = fcs32 ? CRC32_INIT : CRC16_INIT;
   wire [31:0] crc_good = fcs32 ? CRC32_GOOD : CRC16_GOOD;

   // Outcome of a closing packet.
   wire pkt_invalid = close_ev & hdlc_mode & (bcnt_nx != 3'h0);
   wire pkt_small = close_ev & (cnt_nx < min_pkt_size);
   wire pkt_large = close_ev & big_nx;
   wire pkt_fcs_bad = close_ev & fcs_on & ~pkt_invalid & (crc_nx != crc_good);
   wire pkt_size_viol = pkt_small | pkt_large;
   wire pkt_err = pkt_invalid | pkt_size_viol | pkt_fcs_bad | discard_all;

   always_ff @(posedge clk) begin
      if (rst) begin
         in_pkt_q <= 1'b0;
         esc_q <= 1'b0;
         cnt_q <= 16'h0;
         crc_q <= CRC32_INIT;
         big_q <= 1'b0;
      end else if (end_ev || abort_ev || chunk_end) begin
         in_pkt_q <= end_ev;
         esc_q <= 1'b0;
         cnt_q <= 16'h0;
         crc_q <= crc_init;
         big_q <= 1'b0;
      end else begin
         if (abort_hit) begin
            in_pkt_q <= 1'b0;
         end
         if (x86 && byte_done) begin
            esc_q <= (sh_nx == ESC_BYTE);
         end
         cnt_q <= cnt_nx;
         crc_q <= crc_nx;
         big_q <= big_nx;
      end
   end

   // ---------------- FCS removal delay line ----------------
   // When drop_fcs is set outside clear-channel mode, bytes are held back by the FCS length so the trailing FCS never leaves the block.
   logic [7:0] dl_q [0:3];
   wire emit_ok = data_ev & ~big_nx & ~discard_all;
   wire emit_now = emit_ok & ((drop_n == 3'h0) || (cnt_q >= {13'h0, drop_n}));
   wire [7:0] emit_b = (drop_n == 3'h0) ? data_b : dl_q[drop_n[1:0] - 2'h1];

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            dl_q[i] <= 8'h00;
         end
      end else if (data_ev) begin
         dl_q[0] <= data_b;
         for (int i = 1; i < 4; i++) begin
            dl_q[i] <= dl_q[i-1];
         end
      end
   end

   srpp_out_t out_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         out_q <= '0;
      end else begin
         out_q.valid <= emit_now;
         out_q.data <= emit_now ? emit_b : out_q.data;
         out_q.eop <= close_ev | chunk_end | (abort_ev & ~clear_mode);
         out_q.err <= close_ev ? pkt_err : (abort_ev & ~clear_mode);
      end
   end

   // ---------------- Error counters and status ----------------
   logic [CNT_W-1:0] fcs_cnt_q;
   logic [CNT_W-1:0] abort_cnt_q;
   logic [CNT_W-1:0] size_cnt_q;

   // Counters saturate instead of wrapping, so a non-zero status never falls back to zero.
   always_ff @(posedge clk) begin
      if (rst) begin
         fcs_cnt_q <= '0;
         abort_cnt_q <= '0;
         size_cnt_q <= '0;
      end else begin
         if (pkt_fcs_bad && !(&fcs_cnt_q)) begin
            fcs_cnt_q <= fcs_cnt_q + 1'b1;
         end
         if (abort_ev && !clear_mode && !(&abort_cnt_q)) begin
            abort_cnt_q <= abort_cnt_q + 1'b1;
         end
         if (pkt_size_viol && !(&size_cnt_q)) begin
            size_cnt_q <= size_cnt_q + 1'b1;
         end
      end
   end

   wire [2:0] stat_nx = {fcs_cnt_q != '0, abort_cnt_q != '0, size_cnt_q != '0};

   always_ff @(posedge clk) begin
      if (rst) begin
         stat_q <= 3'h0;
      end else begin
         stat_q <= stat_nx;
      end
   end

   // ---------------- Latched flags ----------------
   logic [7:0] lat_set;

   always_comb begin
      lat_set = 8'h00;
      lat_set[LAT_FCS_ERR_PKT] = pkt_fcs_bad;
      lat_set[LAT_ABORT_PKT] = abort_ev & ~clear_mode;
      lat_set[LAT_INVALID_PKT] = pkt_invalid;
      lat_set[LAT_SMALL_PKT] = pkt_small;
      lat_set[LAT_LARGE_PKT] = pkt_large;
      lat_set[2:0] = stat_nx & ~stat_q;
   end

   wire [7:0] lat_clr = (wr_ok && idx == IDX_RX_PACKET_STATUS_LATCHED) ? pwdata[7:0] : 8'h00;

   // A new event in the cycle of a clear keeps the flag set.
   always_ff @(posedge clk) begin
      if (rst) begin
         lat_q <= RST_RX_PACKET_STATUS_LATCHED;
      end else begin
         lat_q <= (lat_q & ~lat_clr) | lat_set;
      end
   end

   logic irq_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(lat_q & ie_q);
      end
   end

   // ---------------- APB slave ----------------
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= RST_RX_PACKET_CONTROL;
         max_lo_q <= RST_RX_MAX_SIZE_LOW;
         max_hi_q <= RST_RX_MAX_SIZE_HIGH;
         ie_q <= RST_RX_IRQ_ENABLE;
         mode_q <= RST_RX_MODE_CONFIG;
      end else if (wr_ok) begin
         unique case (idx)
            IDX_RX_PACKET_CONTROL: ctrl_q <= pwdata[7:0] & CTL_WRITE_MASK;
            IDX_RX_MAX_SIZE_LOW: max_lo_q <= pwdata[7:0];
            IDX_RX_MAX_SIZE_HIGH: max_hi_q <= pwdata[7:0];
            IDX_RX_IRQ_ENABLE: ie_q <= pwdata[7:0];
            IDX_RX_MODE_CONFIG: mode_q <= {7'h00, pwdata[MODE_X86_ENABLE]};
            default: ;
         endcase
      end
   end

   logic [7:0] rd_byte;

   always_comb begin
      rd_byte = 8'h00;
      unique case (idx)
         IDX_RX_PACKET_CONTROL: rd_byte = ctrl_q;
         IDX_RX_MAX_SIZE_LOW: rd_byte = max_lo_q;
         IDX_RX_MAX_SIZE_HIGH: rd_byte = max_hi_q;
         IDX_RX_PACKET_STATUS: rd_byte = {5'h00, stat_q};
         IDX_RX_PACKET_STATUS_LATCHED: rd_byte = lat_q;
         IDX_RX_IRQ_ENABLE: rd_byte = ie_q;
         IDX_RX_MODE_CONFIG: rd_byte = mode_q;
         default: rd_byte = 8'h00;
      endcase
   end

   // The answer is prepared in the setup cycle, so every access completes without wait states.
   always_ff @(posedge clk) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else if (psel && !penable && !pready_q) begin
         pready_q <= 1'b1;
         pslverr_q <= ~reg_known(idx);
         prdata_q <= {24'h0, rd_byte};
      end else begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign rx_out = out_q;
   assign irq = irq_q;

endmodule

/* File: dv/srpp_link_model.sv */
// Link partner model: serial bit source with stuffing, scrambling and bit order.
`timescale 1ns/1ps
module srpp_link_model (
   output logic rx_clk_pin,
   output logic rx_data_pin,
   output logic rx_sync_pin
);
   logic reorder = 1'b0;
   logic scr = 1'b0;
   logic [42:0] hist = '0;
   int ones = 0;
   initial begin
      rx_clk_pin = 1'b0;
      rx_data_pin = 1'b0;
      rx_sync_pin = 1'b0;
   end
   // History tracks every line bit, because the receiver shifts every raw bit into its descrambler in all modes.
   task automatic bit_o(input logic b, input logic s);
      logic l;
      l = b ^ (scr & hist[42]);
      hist = {hist[41:0], l};
      rx_data_pin = l;
      rx_sync_pin = s;
      #62.5 rx_clk_pin = 1'b1;
      #62.5 rx_clk_pin = 1'b0;
   endtask
   task automatic flag_o();
      for (int i = 0; i < 8; i++) bit_o((i != 0) && (i != 7), 1'b0);
      ones = 0;
   endtask
   task automatic byte_o(input logic [7:0] d, input logic stuff);
      logic b;
      for (int i = 0; i < 8; i++) begin
         b = reorder ? d[i] : d[7-i];
         bit_o(b, i == 0);
         ones = b ? ones + 1 : 0;
         if (stuff && ones == 5) begin
            bit_o(1'b0, 1'b0);
            ones = 0;
         end
      end
   endtask
   task automatic run_o(input logic v, input int n);
      repeat (n) bit_o(v, 1'b0);
   endtask
   // The clock stands low between frames and the data line shows no stale value.
   task automatic idle_o();
      rx_data_pin = ~rx_data_pin;
      rx_sync_pin = 1'b0;
   endtask
endmodule

/* File: dv/srpp_chk.sv */
// Port-level assertions for the serial receive packet processor.
`timescale 1ns/1ps
module srpp_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [srpp_pkg::APB_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rx_clk_pin,
   input wire logic rx_data_pin,
   input wire logic rx_sync_pin,
   input wire logic [15:0] min_pkt_size,
   input srpp_pkg::srpp_out_t rx_out,
   input wire logic irq
);
   import srpp_pkg::*;
   logic mapped;
   assign mapped = paddr inside {12'h404, 12'h408, 12'h40c, 12'h410, 12'h414, 12'h418, 12'h480};
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_APB_ANSWER: assert property (psel && !penable && !pready |=> pready)
      else $error("no ready after setup");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("slave error without ready");
   AST_UNMAPPED: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   AST_MAPPED: assert property (pready && mapped |-> !pslverr && prdata[31:8] == 24'h0)
      else $error("mapped access refused or upper bits set");
   AST_PRDATA_HOLD: assert property (!pready |-> $stable(prdata))
      else $error("read data moved outside an access");
   AST_VALID_PULSE: assert property (rx_out.valid |=> !rx_out.valid [*4])
      else $error("byte strobe too long");
   AST_EOP_PULSE: assert property (rx_out.eop |=> !rx_out.eop [*8])
      else $error("end strobe too long");
   AST_RESET_QUIET: assert property ($fell(rst) |-> !pready && !irq && !rx_out.valid)
      else $error("outputs active after reset");
   COV_BAD: cover property (rx_out.eop && rx_out.err);
   COV_GOOD: cover property (rx_out.eop && !rx_out.err);
   COV_SLVERR: cover property (pslverr);
   COV_IRQ: cover property ($rose(irq));
endmodule
bind srpp_top srpp_chk chk_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin),
   .rx_sync_pin(rx_sync_pin), .min_pkt_size(min_pkt_size), .rx_out(rx_out), .irq(irq));

/* File: dv/tb_serial_rx_packet_processor.sv */
// Self-checking testbench for the serial receive packet processor.
`timescale 1ns/1ps
module tb_serial_rx_packet_processor;
   import srpp_pkg::*;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic [APB_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic rx_clk_pin, rx_data_pin, rx_sync_pin, last_err;
   logic [15:0] min_pkt_size;
   srpp_out_t rx_out;
   logic [7:0] got[$];
   int n_eop = 0;
   int err_total = 0;
   int checks_done = 0;
   srpp_top #(.CNT_W(2)) dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin),
      .rx_sync_pin(rx_sync_pin), .min_pkt_size(min_pkt_size), .rx_out(rx_out), .irq(irq));
   srpp_link_model link_u (.rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin),
      .rx_sync_pin(rx_sync_pin));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rx_out.valid === 1'b1) got.push_back(rx_out.data);
      if (rx_out.eop === 1'b1) begin
         n_eop++;
         last_err = rx_out.err;
      end
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // Holds the request until pready is sampled high; no wait-state count is assumed.
   task automatic apb(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      chk("pready", pready, 1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
   endtask
   task automatic rdc(input logic [IDX_W-1:0] idx, input logic [7:0] x, input string n);
      logic [31:0] r;
      logic e;
      apb(1'b0, idx, 8'h00, r, e);
      chk(n, r, {24'h0, x});
   endtask
   task automatic wait_eop(input int n);
      int k;
      k = 0;
      while (n_eop < n && k < 400) begin
         @(posedge clk);
         k++;
      end
      chk("eop_count", n_eop, n);
   endtask
   // Byte-stuffed transmit of one octet, as the X.86 partner would send it.
   task automatic esc_o(input logic [7:0] b);
      if (b == FLAG_BYTE || b == ESC_BYTE) begin
         link_u.byte_o(ESC_BYTE, 1'b0);
         link_u.byte_o(b ^ ESC_XOR, 1'b0);
      end else begin
         link_u.byte_o(b, 1'b0);
      end
   endtask
   task automatic frame(input logic [7:0] q[$], input int tail);
      got.delete();
      n_eop = 0;
      link_u.flag_o();
      link_u.flag_o();
      foreach (q[i]) link_u.byte_o(q[i], 1'b1);
      if (tail == 1) link_u.run_o(1'b1, 7);
      else link_u.run_o(1'b0, tail);
      link_u.flag_o();
      link_u.idle_o();
      wait_eop(1);
   endtask
   task automatic cmp_q(input logic [7:0] q[$]);
      chk("byte_count", got.size(), q.size());
      foreach (q[i]) chk("byte", got[i], q[i]);
   endtask
   function automatic logic [31:0] crc(input logic [7:0] q[$], input logic w);
      logic [31:0] c;
      c = w ? CRC32_INIT : CRC16_INIT;
      foreach (q[i]) for (int b = 0; b < 8; b++)
         c = (c >> 1) ^ ((c[0] ^ q[i][b]) ? (w ? CRC32_POLY : CRC16_POLY) : 32'h0);
      return ~c;
   endfunction
   task automatic sc_regs();
      logic [31:0] r;
      logic e;
      rdc(IDX_RX_PACKET_CONTROL, 8'h00, "ctl_reset");
      rdc(IDX_RX_MAX_SIZE_LOW, 8'he0, "max_lo_reset");
      rdc(IDX_RX_MAX_SIZE_HIGH, 8'h07, "max_hi_reset");
      rdc(IDX_RX_PACKET_STATUS, 8'h00, "status_reset");
      rdc(IDX_RX_PACKET_STATUS_LATCHED, 8'h00, "latched_reset");
      wr(IDX_RX_PACKET_CONTROL, 8'hff);
      rdc(IDX_RX_PACKET_CONTROL, 8'h3f, "ctl_rw");
      wr(IDX_RX_PACKET_STATUS, 8'h07);
      rdc(IDX_RX_PACKET_STATUS, 8'h00, "status_ro");
      apb(1'b0, 10'h107, 8'h00, r, e);
      chk("unmapped_err", e, 1);
   endtask
   task automatic sc_fcs();
      logic [7:0] q[$];
      logic [31:0] f;
      q = '{8'ha5, 8'hff, 8'h01};
      f = crc(q, 1'b0);
      q.push_back(f[7:0]);
      q.push_back(f[15:8]);
      wr(IDX_RX_PACKET_CONTROL, 8'h14);
      frame(q, 0);
      chk("fcs16_err", last_err, 0);
      chk("strip_len", got.size(), 3);
      wr(IDX_RX_PACKET_CONTROL, 8'h1c);
      frame(q, 0);
      cmp_q(q);
      wr(IDX_RX_PACKET_CONTROL, 8'h24);
      frame(q, 0);
      chk("nofcs_err", last_err, 0);
      wr(IDX_RX_PACKET_CONTROL, 8'h04);
      frame(q, 0);
      chk("fcs32_err", last_err, 1);
      q[4] = ~q[4];
      wr(IDX_RX_PACKET_CONTROL, 8'h14);
      frame(q, 0);
      chk("bad_fcs_err", last_err, 1);
      rdc(IDX_RX_PACKET_STATUS_LATCHED, 8'h84, "fcs_latched");
      rdc(IDX_RX_PACKET_STATUS, 8'h04, "fcs_status");
      wr(IDX_RX_IRQ_ENABLE, 8'h80);
      repeat (2) @(posedge clk);
      chk("irq_set", irq, 1);
      wr(IDX_RX_PACKET_STATUS_LATCHED, 8'h00);
      rdc(IDX_RX_PACKET_STATUS_LATCHED, 8'h84, "w0_kept");
      wr(IDX_RX_PACKET_STATUS_LATCHED, 8'h84);
      rdc(IDX_RX_PACKET_STATUS_LATCHED, 8'h00, "w1_cleared");
      chk("irq_clear", irq, 0);
      wr(IDX_RX_IRQ_ENABLE, 8'h00);
   endtask
   task automatic sc_order();
      wr(IDX_RX_PACKET_CONTROL, 8'h26);
      link_u.reorder = 1'b1;
      frame('{8'h12, 8'h80}, 0);
      cmp_q('{8'h12, 8'h80});
      link_u.reorder = 1'b0;
      link_u.scr = 1'b1;
      wr(IDX_RX_PACKET_CONTROL, 8'h20);
      frame('{8'hc3, 8'h5a}, 0);
      cmp_q('{8'hc3, 8'h5a});
      link_u.scr = 1'b0;
   endtask
   task automatic sc_size();
      wr(IDX_RX_PACKET_CONTROL, 8'h24);
      wr(IDX_RX_MAX_SIZE_LOW, 8'h04);
      wr(IDX_RX_MAX_SIZE_HIGH, 8'h00);
      frame('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06}, 0);
      chk("large_err", last_err, 1);
      chk("large_len", got.size(), 4);
      rdc(IDX_RX_PACKET_STATUS_LATCHED, 8'h09, "large_latched");
      wr(IDX_RX_PACKET_STATUS_LATCHED, 8'hff);
      wr(IDX_RX_MAX_SIZE_LOW, 8'h10);
      @(posedge clk);
      min_pkt_size <= 16'h0004;
      frame('{8'h01, 8'h02}, 0);
      chk("small_err", last_err, 1);
      rdc(IDX_RX_PACKET_STATUS_LATCHED, 8'h10, "small_latched");
      @(posedge clk);
      min_pkt_size <= 16'h0002;
      wr(IDX_RX_PACKET_STATUS_LATCHED, 8'hff);
      frame('{8'h11, 8'h22}, 1);
      rdc(IDX_RX_PACKET_STATUS_LATCHED, 8'h42, "abort_latched");
      wr(IDX_RX_PACKET_STATUS_LATCHED, 8'hff);
      frame('{8'h33, 8'h44}, 3);
      rdc(IDX_RX_PACKET_STATUS_LATCHED, 8'h20, "invalid_latched");
      wr(IDX_RX_MAX_SIZE_LOW, 8'h01);
      frame('{8'h55}, 0);
      chk("discard_len", got.size(), 0);
   endtask
   task automatic sc_clear();
      logic [7:0] q[$];
      q = '{8'h7e, 8'h01, 8'hff, 8'h7d, 8'h80, 8'h3c};
      wr(IDX_RX_PACKET_CONTROL, 8'h05);
      wr(IDX_RX_MAX_SIZE_LOW, 8'h03);
      got.delete();
      n_eop = 0;
      foreach (q[i]) link_u.byte_o(q[i], 1'b0);
      link_u.idle_o();
      wait_eop(2);
      chk("chunk_count", n_eop, 2);
      cmp_q(q);
   endtask
   // Control bits 2 to 5 are set against X.86 mode, which must override the three FCS bits.
   task automatic sc_x86();
      logic [7:0] q[$];
      logic [31:0] f;
      q = '{8'h7e, 8'h11, 8'h7d};
      f = crc(q, 1'b1);
      wr(IDX_RX_MODE_CONFIG, 8'h01);
      wr(IDX_RX_PACKET_CONTROL, 8'h3c);
      wr(IDX_RX_MAX_SIZE_LOW, 8'h10);
      got.delete();
      n_eop = 0;
      link_u.byte_o(FLAG_BYTE, 1'b0);
      foreach (q[i]) esc_o(q[i]);
      for (int i = 0; i < 4; i++) esc_o(f[8*i+:8]);
      link_u.byte_o(FLAG_BYTE, 1'b0);
      link_u.idle_o();
      wait_eop(1);
      chk("x86_err", last_err, 0);
      cmp_q(q);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #400000;
      err_total++;
      wrap_up();
   end
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      min_pkt_size = 16'h0002;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      sc_regs();
      sc_fcs();
      sc_order();
      sc_size();
      sc_clear();
      sc_x86();
      wrap_up();
   end
endmodule
